// ==== logic/wdp_top.sv ====
// watchdog timer with count source protection, wishbone registers and interrupts
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "wdp_map.svh"
module wdp_top #(
	parameter int LSOSC_DIV = `WDP_LSOSC_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic auto_start_option_bit,
	input wire logic protect_after_reset,
	input wire logic wait_mode,
	input wire logic bus_hold,
	input wire logic osc_stop_event,
	output logic wdt_reset_q,
	output logic wdt_nmi_q,
	output logic irq_q,
	output logic osc_off_q,
	output logic stop_mode_q,
	output logic lsosc_run_q
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	wdp_pkg::wdp_state_t s_q;
	wdp_pkg::wdp_state_t s_d;

	logic wr_stb;
	logic [31:0] rd_data;
	logic ls_tick;
	logic [7:0] wbyte;
	logic [5:0] widx;

	assign wbyte = wb_dat_i[7:0];
	assign widx = wb_adr_i[7:2];

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	wdp_wb u_wb (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.wr_stb(wr_stb),
		.rd_data(rd_data)
	);

	// ----------------------------------------------------------------
	// low-speed oscillator
	// ----------------------------------------------------------------
	// runs unless switched off; protection forces it on
	wdp_tick #(
		.DIV(LSOSC_DIV)
	) u_lsosc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.run(s_q.osc_run),
		.tick(ls_tick)
	);

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	logic wr_refresh;
	logic wr_start;
	logic wr_protect;
	logic wr_clkmode;
	logic wr_procmode;
	logic wr_detect;
	logic wr_sts;
	logic wr_msk;
	logic wr_presc;

	assign wr_refresh = wr_stb & (widx == `WDP_REFRESH_OFS >> 2);
	assign wr_start = wr_stb & (widx == `WDP_START_OFS >> 2);
	assign wr_protect = wr_stb & (widx == `WDP_PROTECT_OFS >> 2);
	assign wr_clkmode = wr_stb & (widx == `WDP_CLKMODE_OFS >> 2);
	assign wr_procmode = wr_stb & (widx == `WDP_PROCMODE_OFS >> 2);
	assign wr_detect = wr_stb & (widx == `WDP_DETECT_OFS >> 2);
	assign wr_sts = wr_stb & (widx == `WDP_IRQ_STS_OFS >> 2);
	assign wr_msk = wr_stb & (widx == `WDP_IRQ_MSK_OFS >> 2);
	assign wr_presc = wr_stb & (widx == `WDP_PRESC_OFS >> 2);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h00000000;
		unique case (wb_adr_i[7:2])
			`WDP_PROTECT_OFS >> 2: begin
				rd_data[`WDP_PROTECT_BIT] = s_q.protect;
			end
			`WDP_CLKMODE_OFS >> 2: begin
				rd_data[`WDP_STOPREQ_BIT] = s_q.stop_req;
				rd_data[`WDP_OSCOFF_BIT] = s_q.osc_off;
			end
			`WDP_PROCMODE_OFS >> 2: begin
				rd_data[`WDP_UFACT_BIT] = s_q.uf_act;
			end
			`WDP_DETECT_OFS >> 2: begin
				rd_data[`WDP_OSCFLAG_BIT] = s_q.osc_flag;
				rd_data[`WDP_WDTFLAG_BIT] = s_q.wdt_flag;
			end
			`WDP_IRQ_STS_OFS >> 2: begin
				rd_data[1:0] = s_q.sts;
			end
			`WDP_IRQ_MSK_OFS >> 2: begin
				rd_data[1:0] = s_q.msk;
			end
			`WDP_COUNT_OFS >> 2: begin
				rd_data[14:0] = s_q.cnt;
			end
			`WDP_PRESC_OFS >> 2: begin
				rd_data[`WDP_PRESC_SEL_BIT] = s_q.presc_sel;
			end
			// refresh, start and unmapped words read as zero
			default: begin
				rd_data = 32'h00000000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic run_cnt;
	logic presc_tick;
	logic step;
	logic uf;
	logic refresh;
	logic uf_irq;
	logic [7:0] presc_div;

	always_comb begin
		s_d = s_q;
		presc_div = s_q.presc_sel ? `WDP_PRESC_LONG : `WDP_PRESC_SHORT;
		run_cnt = 1'b0;
		presc_tick = 1'b0;
		step = 1'b0;
		uf = 1'b0;
		refresh = 1'b0;
		uf_irq = 1'b0;

		// straps are caught on the first edge after reset release
		if (!s_q.init_done) begin
			s_d.init_done = 1'b1;
			s_d.started = ~auto_start_option_bit;
			s_d.protect = protect_after_reset;
		end

		// software start, any value
		if (wr_start) begin
			s_d.started = 1'b1;
		end

		// protection can only be set, never cleared by software
		if (wr_protect && wbyte[`WDP_PROTECT_BIT]) begin
			s_d.protect = 1'b1;
		end

		if (wr_clkmode) begin
			s_d.stop_req = wbyte[`WDP_STOPREQ_BIT];
			s_d.osc_off = wbyte[`WDP_OSCOFF_BIT];
		end
		if (wr_procmode) begin
			s_d.uf_act = wbyte[`WDP_UFACT_BIT];
		end
		if (wr_presc) begin
			s_d.presc_sel = wbyte[`WDP_PRESC_SEL_BIT];
		end
		if (wr_msk) begin
			s_d.msk = wbyte[1:0];
		end

		// protected mode pins down oscillator, stop mode and action
		if (s_d.protect) begin
			s_d.osc_off = 1'b0;
			s_d.stop_req = 1'b0;
			s_d.uf_act = 1'b1;
		end
		s_d.osc_run = ~s_d.osc_off;

		// refresh sequence: 00h arms, FFh right after it reloads
		if (wr_refresh) begin
			if (s_q.armed && wbyte == `WDP_REFRESH_SECOND) begin
				refresh = 1'b1;
			end
			s_d.armed = (wbyte == `WDP_REFRESH_FIRST);
		end

		// count source and stop conditions
		if (s_q.protect) begin
			run_cnt = s_q.started;
			step = run_cnt & ls_tick;
		end else begin
			run_cnt = s_q.started & ~wait_mode & ~bus_hold & ~s_q.stop_req;
			if (run_cnt) begin
				// prescaler kept across refreshes, cleared only by reset
				if (s_q.presc == presc_div - 8'h01) begin
					s_d.presc = 8'h00;
					presc_tick = 1'b1;
				end else begin
					s_d.presc = s_q.presc + 8'h01;
				end
			end
			step = presc_tick;
		end

		// decrement and underflow
		if (step) begin
			if (s_q.protect) begin
				uf = (s_q.cnt[14:3] == 12'h000);
				s_d.cnt = s_q.cnt - `WDP_PROT_STEP;
			end else begin
				uf = (s_q.cnt == 15'h0000);
				s_d.cnt = s_q.cnt - 15'h0001;
			end
		end
		if (uf || refresh) begin
			s_d.cnt = `WDP_CNT_RELOAD;
		end

		// underflow action
		s_d.rst_pulse = uf & (s_q.protect | s_q.uf_act);
		uf_irq = uf & ~s_q.protect & ~s_q.uf_act;

		// detect flags: a zero clears, a new event wins
		if (wr_detect) begin
			if (!wbyte[`WDP_WDTFLAG_BIT]) begin
				s_d.wdt_flag = 1'b0;
			end
			if (!wbyte[`WDP_OSCFLAG_BIT]) begin
				s_d.osc_flag = 1'b0;
			end
		end
		if (uf_irq) begin
			s_d.wdt_flag = 1'b1;
		end
		if (osc_stop_event) begin
			s_d.osc_flag = 1'b1;
		end

		// sticky status, write one to clear, set wins
		if (wr_sts) begin
			s_d.sts = s_q.sts & ~wbyte[1:0];
		end
		if (uf_irq) begin
			s_d.sts[`WDP_STS_WDT_BIT] = 1'b1;
		end
		if (osc_stop_event) begin
			s_d.sts[`WDP_STS_OSC_BIT] = 1'b1;
		end
		s_d.irq = |(s_d.sts & s_d.msk);

		// shared vector, no mask in its path
		s_d.nmi = s_d.wdt_flag | s_d.osc_flag;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q.init_done <= 1'b0;
			s_q.started <= 1'b0;
			s_q.protect <= 1'b0;
			s_q.osc_off <= 1'b0;
			s_q.osc_run <= 1'b1;
			s_q.stop_req <= 1'b0;
			s_q.uf_act <= 1'b0;
			s_q.presc_sel <= 1'b0;
			s_q.cnt <= `WDP_CNT_RELOAD;
			s_q.presc <= 8'h00;
			s_q.armed <= 1'b0;
			s_q.wdt_flag <= 1'b0;
			s_q.osc_flag <= 1'b0;
			s_q.sts <= 2'h0;
			s_q.msk <= 2'h0;
			s_q.rst_pulse <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.nmi <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wdt_reset_q = s_q.rst_pulse;
	assign wdt_nmi_q = s_q.nmi;
	assign irq_q = s_q.irq;
	assign osc_off_q = s_q.osc_off;
	assign stop_mode_q = s_q.stop_req;
	assign lsosc_run_q = s_q.osc_run;

endmodule // wdp_top

// ==== logic/wdp_map.svh ====
// register offsets, field positions, reset values and timing counts of the watchdog
//
// Functional notes
// - protected mode counts the low-speed oscillator
// - protected: drop three LSBs, 4096-tick period
// - reload on reset, underflow, 00h/FFh refresh
// - auto-start bit 1: wait for start write
// - auto-start bit 0: count from reset release
// - protected counter ignores wait and bus hold
// - protected underflow always resets, never interrupts
// - protect clears osc-off, later ones ignored
// - protect forces underflow action to reset
// - protect blocks stop-mode request writes
// - watchdog interrupt is non-maskable
// - watchdog and osc-detect share one vector
// - detect flag set on interrupt, cleared by zero
// - unprotected, action bit 0: interrupt on underflow
// - unprotected counts CPU clock through prescaler
// - refresh leaves prescaler, only reset clears it
`ifndef WDP_MAP_SVH
`define WDP_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define WDP_REFRESH_OFS 8'h00
`define WDP_START_OFS 8'h04
`define WDP_PROTECT_OFS 8'h08
`define WDP_CLKMODE_OFS 8'h0C
`define WDP_PROCMODE_OFS 8'h10
`define WDP_DETECT_OFS 8'h14
`define WDP_IRQ_STS_OFS 8'h18
`define WDP_IRQ_MSK_OFS 8'h1C
`define WDP_COUNT_OFS 8'h20
`define WDP_PRESC_OFS 8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDP_PROTECT_BIT 7
`define WDP_STOPREQ_BIT 0
`define WDP_OSCOFF_BIT 4
`define WDP_UFACT_BIT 2
`define WDP_OSCFLAG_BIT 2
`define WDP_WDTFLAG_BIT 3
`define WDP_PRESC_SEL_BIT 7
`define WDP_STS_WDT_BIT 0
`define WDP_STS_OSC_BIT 1

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define WDP_REFRESH_FIRST 8'h00
`define WDP_REFRESH_SECOND 8'hFF
`define WDP_CNT_RELOAD 15'h7FFF
`define WDP_PROT_STEP 15'h0008
`define WDP_PRESC_SHORT 8'h10
`define WDP_PRESC_LONG 8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDP_SYS_PERIOD_NS 8
`define WDP_LSOSC_PERIOD_NS 8000
`define WDP_LSOSC_CYCLES (`WDP_LSOSC_PERIOD_NS / `WDP_SYS_PERIOD_NS)

`endif

// ==== logic/wdp_pkg.sv ====
// types of the watchdog block
package wdp_pkg;

	typedef struct packed {
		logic init_done;
		logic started;
		logic protect;
		logic osc_off;
		logic osc_run;
		logic stop_req;
		logic uf_act;
		logic presc_sel;
		logic [14:0] cnt;
		logic [7:0] presc;
		logic armed;
		logic wdt_flag;
		logic osc_flag;
		logic [1:0] sts;
		logic [1:0] msk;
		logic rst_pulse;
		logic irq;
		logic nmi;
	} wdp_state_t;

endpackage

// ==== logic/wdp_tick.sv ====
// low-speed oscillator model: one tick per oscillator period while it runs
`timescale 1ns/1ps
module wdp_tick #(
	parameter int DIV = 1000
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic run,
	output logic tick
);

	logic [15:0] div_q;
	logic tick_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (!run) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q == 16'(DIV - 1)) begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;

endmodule // wdp_tick

// ==== logic/wdp_wb.sv ====
// classic wishbone slave front end: single-wait ack, registered read data
`timescale 1ns/1ps
module wdp_wb (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic wr_stb,
	input wire logic [31:0] rd_data
);

	logic ack_q;
	logic [31:0] dat_q;
	logic req;

	// one request per cycle: the ack edge ends it
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_stb = req & wb_we_i & wb_sel_i[0];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i) begin
				dat_q <= rd_data;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule // wdp_wb

// ==== sim/wdp_checker.sv ====
// concurrent checks on the ports of the watchdog top
`timescale 1ns/1ps
module wdp_checker (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic osc_stop_event,
	input wire logic wdt_reset_q,
	input wire logic wdt_nmi_q,
	input wire logic irq_q,
	input wire logic osc_off_q,
	input wire logic lsosc_run_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic wr;
	// write taken at this edge
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not given one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_rst_pulse: assert property (wdt_reset_q |=> !wdt_reset_q)
		else $error("reset request longer than one cycle");
	a_osc_run: assert property (lsosc_run_q == !osc_off_q)
		else $error("oscillator run does not track off bit");
	a_nmi_event: assert property (osc_stop_event |=> wdt_nmi_q)
		else $error("oscillator event did not raise nmi");
	a_nmi_sticky: assert property (wdt_nmi_q && !(wr && wb_adr_i[7:2] == 6'h05) |=> wdt_nmi_q)
		else $error("nmi dropped without detect write");
	a_nmi_unmasked: assert property (wr && wb_adr_i[7:2] == 6'h07 && !osc_stop_event
		|=> wdt_nmi_q == $past(wdt_nmi_q))
		else $error("mask write changed nmi");
	a_mask_off: assert property (wr && wb_adr_i[7:2] == 6'h07 && wb_dat_i[1:0] == 2'h0 |=> !irq_q)
		else $error("irq high with all sources masked");
	a_reset_no_nmi: assert property ($rose(wdt_reset_q) && !$past(osc_stop_event)
		|-> !$rose(wdt_nmi_q))
		else $error("underflow raised nmi with reset");
	c_reset: cover property (wdt_reset_q);
	c_irq: cover property (irq_q);
	c_nmi_clear: cover property ($fell(wdt_nmi_q));
endmodule // wdp_checker

// ==== sim/wdp_top_tb_top.sv ====
// self-checking bench for the watchdog top
`timescale 1ns/1ps
bind wdp_top wdp_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.osc_stop_event(osc_stop_event), .wdt_reset_q(wdt_reset_q), .wdt_nmi_q(wdt_nmi_q),
	.irq_q(irq_q), .osc_off_q(osc_off_q), .lsosc_run_q(lsosc_run_q));
module wdp_top_tb_top;
	logic sys_clk = 0;
	logic nrst = 0;
	logic cyc = 0, stb = 0, we = 0, aso = 1, par = 0, wm = 0, bh = 0, ose = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic ack, nmi, irq, off, stp, run, rq;
	logic [31:0] dout, q, h;
	int bad_count = 0, cmp_count = 0, n;
	wdp_top #(.LSOSC_DIV(4)) dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_ack_o(ack), .wb_dat_o(dout), .auto_start_option_bit(aso),
		.protect_after_reset(par), .wait_mode(wm), .bus_hold(bh), .osc_stop_event(ose),
		.wdt_reset_q(rq), .wdt_nmi_q(nmi), .irq_q(irq), .osc_off_q(off),
		.stop_mode_q(stp), .lsosc_run_q(run));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		sel <= 4'hF;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		q = dout;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (ack !== 1'h1) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	task rst(input logic a, input logic p);
		nrst <= 1'h0;
		aso <= a;
		par <= p;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'h1;
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		rst(1'h1, 1'h0);
		bus(1'h0, 8'h20, 8'h00);
		chk("count", 32'h7FFF, q);
		repeat (40) @(posedge sys_clk);
		bus(1'h0, 8'h20, 8'h00);
		chk("count held", 32'h7FFF, q);
		bus(1'h0, 8'h3C, 8'h00);
		chk("unmapped", 32'h0, q);
		// unprotected: prescaler /16 of the system clock, paused by wait mode
		bus(1'h1, 8'h04, 8'h00);
		repeat (160) @(posedge sys_clk);
		bus(1'h0, 8'h20, 8'h00);
		chk("prescaled", 32'h1, {31'h0, q > 32'h7FF3 && q < 32'h7FF7});
		wm <= 1'h1;
		bus(1'h0, 8'h20, 8'h00);
		h = q;
		repeat (64) @(posedge sys_clk);
		bus(1'h0, 8'h20, 8'h00);
		chk("wait hold", h, q);
		bus(1'h1, 8'h00, 8'h00);
		bus(1'h1, 8'h00, 8'hFF);
		bus(1'h0, 8'h20, 8'h00);
		chk("refresh held", 32'h7FFF, q);
		bus(1'h1, 8'h0C, 8'h10);
		chk("osc off run", 32'h2, {30'h0, off, run});
		bus(1'h1, 8'h0C, 8'h00);
		ose <= 1'h1;
		@(posedge sys_clk);
		ose <= 1'h0;
		@(posedge sys_clk);
		chk("nmi irq", 32'h2, {30'h0, nmi, irq});
		bus(1'h0, 8'h18, 8'h00);
		chk("status", 32'h2, q);
		bus(1'h1, 8'h1C, 8'h02);
		chk("irq on", 32'h1, {31'h0, irq});
		bus(1'h0, 8'h14, 8'h00);
		chk("detect", 32'h4, q);
		bus(1'h1, 8'h14, 8'h00);
		chk("nmi off", 32'h0, {31'h0, nmi});
		bus(1'h1, 8'h18, 8'h02);
		chk("irq off", 32'h0, {31'h0, irq});
		bus(1'h1, 8'h1C, 8'h00);
		bus(1'h1, 8'h08, 8'h80);
		bus(1'h1, 8'h0C, 8'h11);
		bus(1'h0, 8'h0C, 8'h00);
		chk("clk mode", 32'h0, q);
		chk("off stop run", 32'h1, {29'h0, off, stp, run});
		bus(1'h1, 8'h10, 8'h00);
		bus(1'h0, 8'h10, 8'h00);
		chk("action", 32'h4, q);
		wm <= 1'h1;
		bh <= 1'h1;
		bus(1'h1, 8'h04, 8'h00);
		repeat (200) @(posedge sys_clk);
		bus(1'h0, 8'h20, 8'h00);
		chk("step", 32'h7, {29'h0, q[2:0]});
		chk("running", 32'h1, {31'h0, q < 32'h7F00});
		bus(1'h1, 8'h00, 8'h00);
		bus(1'h1, 8'h00, 8'h11);
		bus(1'h1, 8'h00, 8'hFF);
		bus(1'h0, 8'h20, 8'h00);
		chk("no refresh", 32'h1, {31'h0, q < 32'h7F00});
		bus(1'h1, 8'h00, 8'h00);
		bus(1'h1, 8'h00, 8'hFF);
		bus(1'h0, 8'h20, 8'h00);
		chk("refresh", 32'h1, {31'h0, q > 32'h7FE0});
		n = 0;
		while (rq !== 1'h1 && n < 17000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("period", 32'h1, {31'h0, n > 16300 && n < 16400});
		chk("no nmi", 32'h0, {31'h0, nmi});
		rst(1'h0, 1'h1);
		bus(1'h0, 8'h10, 8'h00);
		chk("strap action", 32'h4, q);
		repeat (100) @(posedge sys_clk);
		bus(1'h0, 8'h20, 8'h00);
		chk("auto run", 32'h1, {31'h0, q < 32'h7FFF});
		tally_and_finish();
	end
endmodule // wdp_top_tb_top
